/* File: rcfe_pkg.sv */
// constants, types and state record for the fetch/execute core
package rcfe_pkg;

  // -------------------------------------------------------------
  // sizes
  // -------------------------------------------------------------
  localparam int PC_W = 9;    // 512 instruction words
  localparam int RF_N = 32;   // 32 x 8-bit working registers
  localparam int STK_N = 3;   // return stack depth
  localparam int IRQ_N = 8;   // interrupt sources, vectors 1..8
  localparam int IO_W = 6;    // 64 i/o addresses

  // -------------------------------------------------------------
  // opcodes, bits 15:12 of the instruction word
  // -------------------------------------------------------------
  localparam logic [3:0] OP_ALU2 = 4'h0;
  localparam logic [3:0] OP_ONE = 4'h1;
  localparam logic [3:0] OP_SUBI = 4'h2;
  localparam logic [3:0] OP_ANDI = 4'h3;
  localparam logic [3:0] OP_ORI = 4'h4;
  localparam logic [3:0] OP_LDI = 4'h5;
  localparam logic [3:0] OP_IO = 4'h8;
  localparam logic [3:0] OP_RJMP = 4'hC;
  localparam logic [3:0] OP_RCALL = 4'hD;
  localparam logic [3:0] OP_BREQ = 4'hE;
  localparam logic [3:0] OP_BRNE = 4'hF;

  // single-register and control functions, bits 3:0 under OP_ONE
  localparam logic [3:0] F_INC = 4'h0;
  localparam logic [3:0] F_DEC = 4'h1;
  localparam logic [3:0] F_COM = 4'h2;
  localparam logic [3:0] F_LSR = 4'h3;
  localparam logic [3:0] F_LDZ = 4'h4;
  localparam logic [3:0] F_STZ = 4'h5;
  localparam logic [3:0] F_INZ = 4'h6;
  localparam logic [3:0] F_OUTZ = 4'h7;
  localparam logic [3:0] F_LPM = 4'h8;
  localparam logic [3:0] F_RET = 4'h9;
  localparam logic [3:0] F_RETI = 4'hA;
  localparam logic [3:0] F_SEI = 4'hB;
  localparam logic [3:0] F_CLI = 4'hC;

  // alu functions
  localparam logic [2:0] ALU_ADD = 3'h0;
  localparam logic [2:0] ALU_SUB = 3'h1;
  localparam logic [2:0] ALU_AND = 3'h2;
  localparam logic [2:0] ALU_OR = 3'h3;
  localparam logic [2:0] ALU_INC = 3'h4;
  localparam logic [2:0] ALU_DEC = 3'h5;
  localparam logic [2:0] ALU_COM = 3'h6;
  localparam logic [2:0] ALU_LSR = 3'h7;

  // -------------------------------------------------------------
  // status register, kept inside the core at the top i/o address
  // -------------------------------------------------------------
  localparam logic [5:0] SREG_A = 6'h3F;
  localparam int SREG_I = 7;
  localparam int SREG_Z = 1;
  localparam int SREG_C = 0;
  localparam logic [8:0] RESET_VEC = 9'h000;

  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_IOW = 2'b01,
    ST_LPM1 = 2'b10,
    ST_LPM2 = 2'b11
  } rcfe_st_type;

  typedef struct packed {
    logic [IO_W-1:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } rcfe_io_type;

  typedef struct packed {
    logic [RF_N-1:0][7:0] rf;
    logic [STK_N-1:0][PC_W-1:0] stk;
    logic [PC_W-1:0] fa;
    logic [PC_W-1:0] xpc;
    logic vld;
    rcfe_st_type st;
    logic gie;
    logic zf;
    logic cf;
    logic [4:0] dst;
    rcfe_io_type io;
    logic ack;
    logic [2:0] aid;
  } rcfe_state_type;

  localparam rcfe_state_type STATE_RST = '{fa: RESET_VEC, st: ST_RUN, default: '0};

endpackage : rcfe_pkg

/* File: rcfe_core.sv */
// two-stage fetch/execute 8-bit core with register file, return stack and interrupts
`timescale 1ns/10ps

module rcfe_core (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // program memory, read data returns one cycle after the address
  output logic [rcfe_pkg::PC_W-1:0] pmem_addr,
  input wire logic [15:0] pmem_data,
  // i/o space; read data is sampled in the cycle re is high
  output rcfe_pkg::rcfe_io_type io_bus,
  input wire logic [7:0] io_rdata,
  // interrupt requests (levels) and acknowledge
  input wire logic [rcfe_pkg::IRQ_N-1:0] irq_req,
  output logic irq_ack,
  output logic [2:0] irq_id
);

  // -------------------------------------------------------------
  // alu
  // -------------------------------------------------------------
  function automatic logic [8:0] rcfe_alu(input logic [2:0] f, input logic [7:0] x,
                                          input logic [7:0] y);
    unique case (f)
      rcfe_pkg::ALU_ADD: rcfe_alu = {1'b0, x} + {1'b0, y};
      rcfe_pkg::ALU_SUB: rcfe_alu = {1'b0, x} - {1'b0, y};
      rcfe_pkg::ALU_AND: rcfe_alu = {1'b0, x & y};
      rcfe_pkg::ALU_OR: rcfe_alu = {1'b0, x | y};
      rcfe_pkg::ALU_INC: rcfe_alu = {1'b0, x} + 9'h001;
      rcfe_pkg::ALU_DEC: rcfe_alu = {1'b0, x} - 9'h001;
      rcfe_pkg::ALU_COM: rcfe_alu = {1'b1, ~x};
      rcfe_pkg::ALU_LSR: rcfe_alu = {x[0], 1'b0, x[7:1]};
    endcase
  endfunction : rcfe_alu

  rcfe_pkg::rcfe_state_type s_q, s_d;
  logic [15:0] ins;
  logic [3:0] opc;
  logic [4:0] rd, rr, hd, wi;
  logic [7:0] kk, a, b, wv, sreg;
  logic [15:0] z;
  logic [8:0] zw, tgt, pval, res;
  logic [5:0] ioa, io_ad;
  logic [2:0] aidx, fn;
  logic take, exe, wr, setf, jmp, push, pop, io_in, io_out;

  // -------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------
  // one combinational pass decodes the word on the program bus and
  // builds the whole next state; the fetch holds only for i/o and program reads
  always_comb begin
    s_d = s_q;
    ins = pmem_data;                        // one word, one instruction
    opc = ins[15:12];
    rd = ins[8:4];
    rr = {ins[9], ins[3:0]};
    hd = {1'b1, ins[7:4]};                  // immediates target upper half
    kk = {ins[11:8], ins[3:0]};
    ioa = {ins[10:9], ins[3:0]};
    a = s_q.rf[rd];
    b = s_q.rf[rr];
    z = {s_q.rf[31], s_q.rf[30]};           // indirect pointer pair
    zw = z[9:1];
    tgt = s_q.xpc + ins[8:0] + 9'h001;      // wraps, so a 9-bit offset covers all 512
    sreg = 8'h00;
    sreg[rcfe_pkg::SREG_I] = s_q.gie;
    sreg[rcfe_pkg::SREG_Z] = s_q.zf;
    sreg[rcfe_pkg::SREG_C] = s_q.cf;
    aidx = 3'h0;
    for (int i = rcfe_pkg::IRQ_N - 1; i >= 0; i--) begin
      if (irq_req[i]) aidx = 3'(i);         // lowest index wins
    end
    take = s_q.vld && (s_q.st == rcfe_pkg::ST_RUN) && s_q.gie && (|irq_req);
    exe = s_q.vld && (s_q.st == rcfe_pkg::ST_RUN) && !take;
    wr = 1'b0;
    wi = rd;
    wv = 8'h00;
    fn = rcfe_pkg::ALU_ADD;
    res = 9'h000;
    setf = 1'b0;
    jmp = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    pval = s_q.xpc + 9'h001;
    io_in = 1'b0;
    io_out = 1'b0;
    io_ad = ioa;
    // default is a plain sequential fetch behind execute
    s_d.fa = s_q.fa + 9'h001;
    s_d.xpc = s_q.fa;
    s_d.vld = 1'b1;
    s_d.st = rcfe_pkg::ST_RUN;
    s_d.io.we = 1'b0;
    s_d.io.re = 1'b0;
    s_d.ack = 1'b0;

    // stall states for i/o reads and program memory reads
    unique case (s_q.st)
      rcfe_pkg::ST_IOW: begin
        wr = 1'b1;
        wi = s_q.dst;
        wv = io_rdata;
      end
      rcfe_pkg::ST_LPM1: begin
        s_d.fa = s_q.xpc;                   // refetch where we left off
        s_d.xpc = s_q.xpc;
        s_d.vld = 1'b0;
        s_d.st = rcfe_pkg::ST_LPM2;
      end
      rcfe_pkg::ST_LPM2: begin
        wr = 1'b1;
        wi = s_q.dst;
        wv = z[0] ? pmem_data[15:8] : pmem_data[7:0]; // byte pick by pointer lsb
      end
      rcfe_pkg::ST_RUN: begin
        if (take) begin
          // return to the instruction that was displaced
          push = 1'b1;
          pval = s_q.xpc;
          s_d.fa = {6'h00, aidx} + 9'h001;  // vector table after reset slot
          s_d.vld = 1'b0;
          s_d.gie = 1'b0;
          s_d.ack = 1'b1;
          s_d.aid = aidx;
        end else if (s_q.vld) begin
          unique case (opc)
            rcfe_pkg::OP_ALU2: begin
              fn = {1'b0, ins[11:10]};
              setf = 1'b1;                  // reg-reg op
            end
            rcfe_pkg::OP_SUBI, rcfe_pkg::OP_ANDI, rcfe_pkg::OP_ORI: begin
              fn = 3'(opc - 4'h1);
              a = s_q.rf[hd];
              b = kk;
              wi = hd;
              setf = 1'b1;                  // immediate op
            end
            rcfe_pkg::OP_LDI: begin
              wr = 1'b1;
              wi = hd;
              wv = kk;
            end
            rcfe_pkg::OP_IO: begin
              io_in = !ins[11];
              io_out = ins[11];
            end
            rcfe_pkg::OP_RJMP: jmp = 1'b1;
            rcfe_pkg::OP_RCALL: begin
              jmp = 1'b1;
              push = 1'b1;
            end
            rcfe_pkg::OP_BREQ: jmp = s_q.zf;
            rcfe_pkg::OP_BRNE: jmp = !s_q.zf;
            rcfe_pkg::OP_ONE: begin
              unique case (ins[3:0])
                rcfe_pkg::F_INC, rcfe_pkg::F_DEC, rcfe_pkg::F_COM, rcfe_pkg::F_LSR: begin
                  fn = {1'b1, ins[1:0]};
                  setf = 1'b1;              // single-register op
                end
                rcfe_pkg::F_LDZ: begin
                  wr = 1'b1;
                  wv = s_q.rf[z[4:0]];      // high pointer byte ignored
                end
                rcfe_pkg::F_STZ: begin
                  wr = 1'b1;
                  wi = z[4:0];
                  wv = a;
                end
                rcfe_pkg::F_INZ: begin
                  io_in = 1'b1;
                  io_ad = z[5:0];
                end
                rcfe_pkg::F_OUTZ: begin
                  io_out = 1'b1;
                  io_ad = z[5:0];
                end
                rcfe_pkg::F_LPM: begin
                  s_d.fa = zw;              // borrow the program bus
                  s_d.vld = 1'b0;
                  s_d.st = rcfe_pkg::ST_LPM1;
                  s_d.dst = rd;
                end
                rcfe_pkg::F_RET, rcfe_pkg::F_RETI: begin
                  pop = 1'b1;
                  s_d.fa = s_q.stk[0];
                  s_d.vld = 1'b0;
                  if (ins[3:0] == rcfe_pkg::F_RETI) s_d.gie = 1'b1;
                end
                rcfe_pkg::F_SEI: s_d.gie = 1'b1;
                rcfe_pkg::F_CLI: s_d.gie = 1'b0;
                default: ;                  // unused codes act as no-op
              endcase
            end
            default: ;
          endcase
        end
      end
    endcase

    // alu result, flags and write-back in the same cycle
    res = rcfe_alu(fn, a, b);
    if (setf) begin
      s_d.zf = (res[7:0] == 8'h00);
      s_d.cf = res[8];
      wr = 1'b1;
      wv = res[7:0];
    end

    // i/o access; the status register never leaves the core
    if (io_in) begin
      if (io_ad == rcfe_pkg::SREG_A) begin
        wr = 1'b1;
        wv = sreg;
      end else begin
        s_d.io.re = 1'b1;
        s_d.io.addr = io_ad;
        s_d.dst = rd;
        s_d.st = rcfe_pkg::ST_IOW;
        s_d.fa = s_q.fa;                    // hold fetch until data returns
        s_d.vld = 1'b0;
      end
    end
    if (io_out) begin
      if (io_ad == rcfe_pkg::SREG_A) begin
        s_d.gie = a[rcfe_pkg::SREG_I];
        s_d.zf = a[rcfe_pkg::SREG_Z];
        s_d.cf = a[rcfe_pkg::SREG_C];
      end else begin
        s_d.io.we = 1'b1;
        s_d.io.addr = io_ad;
        s_d.io.wdata = a;
      end
    end

    // relative transfer squashes the word already in flight
    if (jmp) begin
      s_d.fa = tgt;
      s_d.vld = 1'b0;
    end

    // return stack: push deepens, pop keeps the deepest entry
    if (push) begin
      s_d.stk[2] = s_q.stk[1];
      s_d.stk[1] = s_q.stk[0];
      s_d.stk[0] = pval;
    end else if (pop) begin
      s_d.stk[0] = s_q.stk[1];
      s_d.stk[1] = s_q.stk[2];
    end

    if (wr) s_d.rf[wi] = wv;                // any register, one cycle
  end

  // state register
  always_ff @(posedge clock) begin
    if (srst) s_q <= rcfe_pkg::STATE_RST;
    else s_q <= s_d;
  end

  // outputs come straight from the state flops
  assign pmem_addr = s_q.fa;                // 9-bit fetch counter
  assign io_bus = s_q.io;
  assign irq_ack = s_q.ack;
  assign irq_id = s_q.aid;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_pipe;
    s_q.vld |-> (s_q.fa == s_q.xpc + 9'h001);
  endproperty
  a_pipe: assert property (p_pipe) else $error("fetch not one word ahead");

  property p_add;
    (exe && opc == rcfe_pkg::OP_ALU2 && ins[11:10] == 2'b00)
      |=> (s_q.rf[$past(rd)] == 8'($past(a) + $past(b)));
  endproperty
  a_add: assert property (p_add) else $error("add result not written");

  property p_imm;
    (exe && opc == rcfe_pkg::OP_LDI) |=> (s_q.rf[$past(hd)] == $past(kk));
  endproperty
  a_imm: assert property (p_imm) else $error("load immediate wrong");

  property p_jump;
    (exe && opc == rcfe_pkg::OP_RJMP) |=> (s_q.fa == $past(tgt)) && !s_q.vld ##1 s_q.vld;
  endproperty
  a_jump: assert property (p_jump) else $error("relative jump wrong");

  property p_call;
    (exe && opc == rcfe_pkg::OP_RCALL) |=> (s_q.stk[0] == $past(s_q.xpc) + 9'h001)
      && (s_q.stk[1] == $past(s_q.stk[0])) && (s_q.stk[2] == $past(s_q.stk[1]));
  endproperty
  a_call: assert property (p_call) else $error("call push wrong");

  property p_ret;
    (exe && opc == rcfe_pkg::OP_ONE && ins[3:0] == rcfe_pkg::F_RET)
      |=> (s_q.fa == $past(s_q.stk[0])) && (s_q.stk[0] == $past(s_q.stk[1]))
      && (s_q.stk[2] == $past(s_q.stk[2]));
  endproperty
  a_ret: assert property (p_ret) else $error("return pop wrong");

  property p_take;
    take |=> s_q.ack && !s_q.gie && (s_q.fa == {6'h00, s_q.aid} + 9'h001)
      && (s_q.stk[0] == $past(s_q.xpc)) ##1 !s_q.ack;
  endproperty
  a_take: assert property (p_take) else $error("interrupt entry wrong");

  property p_gie;
    s_q.ack |-> $past(s_q.gie);
  endproperty
  a_gie: assert property (p_gie) else $error("interrupt taken while disabled");

  property p_prio;
    s_q.ack |-> (($past(irq_req) & ~(8'hFF << (4'(s_q.aid) + 4'h1))) == (8'h01 << s_q.aid));
  endproperty
  a_prio: assert property (p_prio) else $error("interrupt priority wrong");

  sequence s_lpm_steps;
    (s_q.st == rcfe_pkg::ST_LPM1 && s_q.fa == $past(zw)) ##1 (s_q.st == rcfe_pkg::ST_LPM2)
      ##1 (s_q.st == rcfe_pkg::ST_RUN && s_q.vld);
  endsequence
  property p_lpm;
    (exe && opc == rcfe_pkg::OP_ONE && ins[3:0] == rcfe_pkg::F_LPM) |=> s_lpm_steps;
  endproperty
  a_lpm: assert property (p_lpm) else $error("program read sequence wrong");

  sequence s_io_wait;
    (s_q.io.re && s_q.st == rcfe_pkg::ST_IOW) ##1 (!s_q.io.re && s_q.st == rcfe_pkg::ST_RUN);
  endsequence
  property p_io;
    (exe && opc == rcfe_pkg::OP_IO && !ins[11] && ioa != rcfe_pkg::SREG_A)
      |=> (s_q.io.addr == $past(ioa)) and s_io_wait;
  endproperty
  a_io: assert property (p_io) else $error("i/o read wrong");

endmodule : rcfe_core

/* File: rcfe_mem.sv */
// program rom and i/o byte space facing the core
`timescale 1ns/10ps
module rcfe_mem (
  // clock
  input wire logic clock,
  // program side
  input wire logic [rcfe_pkg::PC_W-1:0] pmem_addr,
  output logic [15:0] pmem_data,
  // bench loader for the rom
  input wire logic ld_we,
  input wire logic [8:0] ld_addr,
  input wire logic [15:0] ld_data,
  // i/o side
  input wire rcfe_pkg::rcfe_io_type io_bus,
  output logic [7:0] io_rdata
);
  // -------------------------------------------------------------
  // storage
  // -------------------------------------------------------------
  logic [15:0] rom_q [512];
  logic [7:0] io_q [64];
  logic [7:0] last_q = 8'h00;

  // sync rom with one cycle latency, one whole word per address
  always_ff @(posedge clock) begin
    pmem_data <= rom_q[pmem_addr];
    if (ld_we) begin
      rom_q[ld_addr] <= ld_data;
    end
    if (io_bus.we) begin
      io_q[io_bus.addr] <= io_bus.wdata;
    end
    if (io_bus.re) begin
      last_q <= io_rdata;
    end
  end

  // data only while re is high; inverted stale byte exposes late sampling
  assign io_rdata = io_bus.re ? io_q[io_bus.addr] : ~last_q;
endmodule : rcfe_mem

/* File: tb_top.sv */
// self-checking bench for the fetch/execute core with random operands
`timescale 1ns/10ps
module tb_top;
  // -------------------------------------------------------------
  // clock, wiring and bookkeeping
  // -------------------------------------------------------------
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [8:0] pmem_addr;
  logic [15:0] pmem_data;
  rcfe_pkg::rcfe_io_type io_bus;
  logic [7:0] io_rdata;
  logic [7:0] irq_req = 8'h00;
  logic irq_ack;
  logic [2:0] irq_id;
  logic ld_we = 1'b0;
  logic [8:0] ld_addr = 9'h000;
  logic [15:0] ld_data = 16'h0000;
  logic [13:0] wq[$];
  logic [13:0] eq[$];
  int err_total = 0;
  int samples_checked = 0;
  logic [7:0] a[4];
  logic [7:0] b[4];
  logic [7:0] r;
  logic [7:0] m;
  int id;
  logic [7:0] x, y, c, v;
  logic [15:0] w;

  always #2 clock = ~clock;

  rcfe_core i_rcfe_core (.clock(clock), .srst(srst), .pmem_addr(pmem_addr),
    .pmem_data(pmem_data), .io_bus(io_bus), .io_rdata(io_rdata), .irq_req(irq_req),
    .irq_ack(irq_ack), .irq_id(irq_id));

  rcfe_mem i_rcfe_mem (.clock(clock), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
    .ld_we(ld_we), .ld_addr(ld_addr), .ld_data(ld_data), .io_bus(io_bus),
    .io_rdata(io_rdata));

  // log every i/o write, address above data
  always @(posedge clock) begin
    if (!srst && io_bus.we === 1'b1) begin
      wq.push_back({io_bus.addr, io_bus.wdata});
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // loader keeps ld_we up across back-to-back words
  task automatic ld(int adr, logic [15:0] w);
    @(negedge clock);
    ld_we = 1'b1;
    ld_addr = 9'(adr);
    ld_data = w;
  endtask : ld

  // finish loading, release reset, first fetch must move to word 1
  task automatic start();
    @(negedge clock);
    ld_we = 1'b0;
    wq.delete();
    repeat (12) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    chk("fetch address", 16'h0001, 16'(pmem_addr));
  endtask : start

  task automatic wait_out(int n);
    for (int t = 0; t < 200 && wq.size() < n; t++) @(negedge clock);
    if (wq.size() < n) begin
      err_total++;
      $display("mismatch io write count expected %0d seen %0d", n, wq.size());
      test_done();
    end
  endtask : wait_out

  function automatic logic [15:0] op_io(logic wr, logic [5:0] adr, logic [4:0] rg);
    return {4'h8, wr, adr[5:4], rg, adr[3:0]};
  endfunction : op_io

  // relative target is from plus offset plus one
  function automatic logic [15:0] op_rel(logic [3:0] op, int from, int to);
    logic [11:0] k;
    k = 12'(to - from - 1);
    return {op, k};
  endfunction : op_rel

  // immediate form: constant split around the upper-half register index
  function automatic logic [15:0] op_imm(logic [3:0] op, logic [3:0] d, logic [7:0] k);
    return {op, k[7:4], d, k[3:0]};
  endfunction : op_imm

  function automatic logic [15:0] op_one(logic [4:0] rg, logic [3:0] fc);
    return {4'h1, 3'b000, rg, fc};
  endfunction : op_one

  function automatic logic [7:0] alu(int f, logic [7:0] x, logic [7:0] y);
    case (f)
      0: return x + y;
      1: return x - y;
      2: return x & y;
      default: return x | y;
    endcase
  endfunction : alu

  // hang guard, far above the bench's run time
  initial begin
    #200000;
    err_total++;
    test_done();
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    void'($urandom(3));
    // test one: alu forms, i/o read back, calls and stack overflow
    for (int f = 0; f < 4; f++) begin
      a[f] = (f == 0) ? 8'hFF : 8'($urandom);
      b[f] = (f == 0) ? 8'h01 : 8'($urandom);
      ld(4 * f, {4'h5, a[f][7:4], 4'h0, a[f][3:0]});
      ld(4 * f + 1, {4'h5, b[f][7:4], 4'h1, b[f][3:0]});
      ld(4 * f + 2, {4'h0, 2'(f), 1'b1, 5'd16, 4'h1});
      ld(4 * f + 3, op_io(1'b1, 6'(f), 5'd16));
      eq.push_back({6'(f), alu(f, a[f], b[f])});
    end
    r = alu(3, a[3], b[3]);
    ld(16, op_io(1'b0, 6'h02, 5'd18));
    ld(17, op_io(1'b1, 6'h0A, 5'd18));
    ld(18, op_rel(4'hD, 18, 100));
    ld(19, op_io(1'b1, 6'h0C, 5'd16));
    ld(20, op_rel(4'hD, 20, 210));
    ld(100, op_io(1'b1, 6'h0B, 5'd17));
    ld(101, 16'h1009);
    // three nested calls after the first: the fourth push drops the oldest
    for (int j = 0; j < 3; j++) begin
      ld(210 + 10 * j, op_rel(4'hD, 210 + 10 * j, (j == 2) ? 500 : 220 + 10 * j));
      ld(211 + 10 * j, op_io(1'b1, 6'(35 - j), 5'd16));
      ld(212 + 10 * j, 16'h1009);
    end
    ld(500, 16'h1009);
    eq.push_back({6'h0A, eq[2][7:0]});
    eq.push_back({6'h0B, b[3]});
    eq.push_back({6'h0C, r});
    for (int j = 0; j < 4; j++) eq.push_back({6'((j < 3) ? 33 + j : 35), r});
    start();
    wait_out(11);
    foreach (eq[j]) chk("io write", 16'(eq[j]), 16'(wq[j]));
    $display("test alu, io and stack done");
    // test two: gated, prioritised, vectored interrupts
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 8'h80 : (i == 1) ? 8'hFF : 8'($urandom_range(1, 255));
      srst = 1'b1;
      irq_req = m;
      ld(0, op_rel(4'hC, 0, 400));
      for (int v = 1; v < 9; v++) ld(v, op_io(1'b1, 6'(16 + v), 5'd16));
      ld(9, 16'h1009);
      for (int v = 400; v < 410; v++) ld(v, 16'h0301);
      ld(410, 16'h100B);
      ld(411, op_rel(4'hC, 411, 411));
      start();
      id = 0;
      while (!m[id]) id++;
      for (int t = 0; t < 10; t++) begin
        @(negedge clock);
        chk("ack while disabled", 16'h0000, 16'(irq_ack));
      end
      for (int t = 0; t < 30 && irq_ack !== 1'b1; t++) @(negedge clock);
      if (irq_ack !== 1'b1) begin
        err_total++;
        $display("mismatch irq_ack expected 1 seen %b", irq_ack);
        test_done();
      end
      chk("irq id", 16'(id), 16'(irq_id));
      chk("vector address", 16'(id + 1), 16'(pmem_addr));
      irq_req = 8'h00;
      wait_out(1);
      chk("vector write", {2'b00, 6'(17 + id), 8'h00}, 16'(wq[0]));
      $display("test interrupt %0d done", i);
    end
    // test three: immediates, single-register ops, pointer, status and branches
    x = 8'($urandom);
    y = 8'($urandom);
    c = 8'($urandom);
    w = 16'($urandom);
    srst = 1'b1;
    irq_req = 8'h00;
    ld(0, op_imm(4'h5, 4'h0, x));
    ld(1, op_imm(4'h2, 4'h0, y));
    ld(2, op_io(1'b1, 6'h20, 5'd16));
    ld(3, op_imm(4'h5, 4'h1, x));
    ld(4, op_imm(4'h3, 4'h1, y));
    ld(5, op_imm(4'h4, 4'h1, c));
    ld(6, op_io(1'b1, 6'h21, 5'd17));
    ld(7, op_one(5'd16, rcfe_pkg::F_INC));
    ld(8, op_one(5'd16, rcfe_pkg::F_COM));
    ld(9, op_one(5'd16, rcfe_pkg::F_LSR));
    ld(10, op_one(5'd16, rcfe_pkg::F_DEC));
    ld(11, op_io(1'b1, 6'h22, 5'd16));
    // pointer high byte set so the program read lands on word 173
    ld(12, op_imm(4'h5, 4'hE, 8'h5B));
    ld(13, op_imm(4'h5, 4'hF, 8'h01));
    ld(14, op_one(5'd17, rcfe_pkg::F_STZ));
    ld(15, op_one(5'd18, rcfe_pkg::F_LDZ));
    ld(16, op_io(1'b1, 6'h23, 5'd18));
    ld(17, op_one(5'd16, rcfe_pkg::F_OUTZ));
    ld(18, op_one(5'd19, rcfe_pkg::F_INZ));
    ld(19, op_io(1'b1, 6'h24, 5'd19));
    ld(20, op_one(5'd20, rcfe_pkg::F_LPM));
    ld(21, op_io(1'b1, 6'h25, 5'd20));
    // status write sets zero, so the equal branch skips and the other falls through
    ld(22, op_imm(4'h5, 4'h5, 8'h02));
    ld(23, op_io(1'b1, 6'h3F, 5'd21));
    ld(24, op_io(1'b0, 6'h3F, 5'd22));
    ld(25, op_rel(4'hE, 25, 27));
    ld(26, op_io(1'b1, 6'h26, 5'd16));
    ld(27, op_io(1'b1, 6'h27, 5'd22));
    ld(28, op_rel(4'hF, 28, 30));
    ld(29, op_io(1'b1, 6'h28, 5'd22));
    ld(30, op_rel(4'hC, 30, 30));
    ld(173, w);
    v = x - y + 8'h01;
    v = ~v;
    v = (v >> 1) - 8'h01;
    r = alu(3, alu(2, x, y), c);
    eq.delete();
    eq.push_back({6'h20, alu(1, x, y)});
    eq.push_back({6'h21, r});
    eq.push_back({6'h22, v});
    eq.push_back({6'h23, r});
    eq.push_back({6'h1B, v});
    eq.push_back({6'h24, v});
    eq.push_back({6'h25, w[15:8]});
    eq.push_back({6'h27, 8'h02});
    eq.push_back({6'h28, 8'h02});
    start();
    wait_out(9);
    repeat (8) @(negedge clock);
    chk("io write count", 16'h0009, 16'(wq.size()));
    foreach (eq[j]) chk("io write", 16'(eq[j]), 16'(wq[j]));
    $display("test pointer, immediate and status done");
    test_done();
  end
endmodule : tb_top
